// ### bench/scsp_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// Link checks, sampled on clk
module scsp_link_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serialClk,
	input wire logic chipSelect_n,
	input wire logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic update_n,
	input wire logic modeSerial
);
	// Parallel mode reuses the pins, so it mutes the checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !modeSerial);
	logic [5:0] falls;
	// Clock falls inside the current frame
	always_ff @(posedge clk)
		if (!rst_n || chipSelect_n)
			falls <= 6'h00;
		else if ($fell(serialClk))
			falls <= falls + 6'h01;
	property p_idle; chipSelect_n |-> serialClk; endproperty
	a_idle: assert property (p_idle) else $error("idle clock low");
	property p_count; $rose(chipSelect_n) |-> falls == 6'h18; endproperty
	a_count: assert property (p_count) else $error("bad bit count");
	property p_max; !chipSelect_n |-> falls <= 6'h18; endproperty
	a_max: assert property (p_max) else $error("extra clock");
	property p_gap; $rose(chipSelect_n) |-> chipSelect_n[*4]; endproperty
	a_gap: assert property (p_gap) else $error("short gap");
	property p_csFall; $fell(chipSelect_n) |-> serialClk; endproperty
	a_csFall: assert property (p_csFall) else $error("select fell on low");
	property p_setup; $fell(serialClk) |-> $stable(serialIn); endproperty
	a_setup: assert property (p_setup) else $error("data moved");
	property p_half; $changed(serialClk) |=> $stable(serialClk)[*3]; endproperty
	a_half: assert property (p_half) else $error("short phase");
	property p_sdo; !chipSelect_n && $changed(serialOut) |-> $rose(serialClk); endproperty
	a_sdo: assert property (p_sdo) else $error("output off rise");
	property p_oe; chipSelect_n |-> !serialOutEn; endproperty
	a_oe: assert property (p_oe) else $error("output driven while idle");
	cover property ($rose(chipSelect_n) && !update_n);
	cover property ($rose(chipSelect_n) && update_n);
	cover property ($fell(update_n));
endmodule : scsp_link_asserts
`default_nettype wire

// ### bench/switch_control_serial_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module switch_control_serial_port_tb_top;
	logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, useStrobe = 1'b0, selSerial = 1'b1;
	logic        busy, serialMode;
	logic [23:0] txWord = 24'h000000, rxWord, switchWord, held;
	logic [4:0]  parIn = 5'h00, parallelWord;
	int          errors = 0, check_count = 0;
	// Rows: strobe flag, then word; last row leaves the word held only
	logic [24:0] rows [4] = '{25'h1a5c3e1, 25'h1ffffff, 25'h1000001, 25'h0c3a55a};
	scsp_if link ();
	always #2 clk = ~clk;
	scsp_host u_scsp_host (.clk(clk), .rst_n(rst_n), .link(link), .start(start),
		.txWord(txWord), .useStrobe(useStrobe), .selSerial(selSerial), .parIn(parIn),
		.busy(busy), .rxWord(rxWord));
	scsp_device u_scsp_device (.clk(clk), .rst_n(rst_n), .link(link),
		.switchWord(switchWord), .parallelWord(parallelWord), .serialMode(serialMode));
	scsp_link_asserts u_asserts (.clk(clk), .rst_n(rst_n), .serialClk(link.serialClk),
		.chipSelect_n(link.chipSelect_n), .serialIn(link.serialIn),
		.serialOut(link.serialOut), .serialOutEn(link.serialOutEn),
		.update_n(link.update_n), .modeSerial(link.modeSerial));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Start held until busy shows, so a slow divider tick is not missed
	task automatic send(input logic [23:0] w, input logic s);
		txWord = w;
		useStrobe = s;
		start = 1'b1;
		repeat (40) if (!busy) @(negedge clk);
		start = 1'b0;
		repeat (400) if (busy) @(negedge clk);
		repeat (10) @(negedge clk);
	endtask : send
	task automatic print_verdict();
		if (errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	initial
	begin
		#20000;
		errors++;
		print_verdict();
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(switchWord, 24'h000000);
		held = 24'h000000;
		for (int i = 0; i < 4; i++)
		begin
			send(rows[i][23:0], rows[i][24]);
			if (rows[i][24])
				held = rows[i][23:0];
			chk(switchWord, held);
			if (i > 0)
				chk(rxWord, rows[i-1][23:0]);
		end
		// Strobe fall applies the held word long before the frame ends
		fork
			send(24'h5e17a0, 1'b1);
			begin
				@(negedge link.update_n);
				repeat (36) @(negedge clk);
				chk(switchWord, rows[3][23:0]);
			end
		join
		chk(switchWord, 24'h5e17a0);
		chk({23'h000000, serialMode}, 24'h000001);
		// Mid-run reset: switches clear, link-side shift word survives
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(switchWord, 24'h000000);
		chk({23'h000000, serialMode}, 24'h000000);
		send(24'h3c5a96, 1'b1);
		chk(switchWord, 24'h3c5a96);
		chk(rxWord, 24'h5e17a0);
		selSerial = 1'b0;
		parIn = 5'h15;
		repeat (10) @(negedge clk);
		chk({19'h00000, parallelWord}, 24'h000015);
		chk({23'h000000, serialMode}, 24'h000000);
		print_verdict();
	end
endmodule : switch_control_serial_port_tb_top
`default_nettype wire

// ### verilog/scsp_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "scsp_regs.svh"
// Device end: shift logic runs on the link clock, switches on clk
module scsp_device (
	input  wire logic        clk,
	input  wire logic        rst_n,
	scsp_if.device           link,
	output logic      [23:0] switchWord,
	output logic      [4:0]  parallelWord,
	output logic             serialMode
);
	logic [23:0] shiftReg;
	logic [4:0]  bitCount;
	logic        outBit;
	logic [23:0] holdWord;
	logic        ignoreRest;
	logic        shiftEn;
	// Extra edges past bit 24 are not shifted
	assign ignoreRest = (bitCount == 5'(`SCSP_WORD_BITS));
	assign shiftEn    = ~link.chipSelect_n & link.modeSerial & ~ignoreRest;
	// Select high clears the count; the link side has no other reset
	always_ff @(negedge link.serialClk or posedge link.chipSelect_n)
	begin
		if (link.chipSelect_n)
			bitCount <= `SCSP_ZERO_CNT;
		else if (shiftEn)
			bitCount <= bitCount + 5'h01;
	end
	// Shift on falling link clock, only while selected
	always_ff @(negedge link.serialClk)
	begin
		if (shiftEn)
			shiftReg <= {shiftReg[22:0], link.serialIn};
	end
	// Output moves on rising edge for daisy chain
	always_ff @(posedge link.serialClk)
	begin
		if (!link.chipSelect_n)
			outBit <= shiftReg[23];
	end
	assign link.serialOut   = outBit;
	assign link.serialOutEn = link.modeSerial & ~link.chipSelect_n;
	// Select rise latches the word in serial mode only, held until the next such rise
	always_ff @(posedge link.chipSelect_n)
	begin
		if (link.modeSerial)
			holdWord <= shiftReg;
	end
	logic [2:0] syncIn;
	logic [2:0] syncOut;
	// Active-high copies, so the flops' reset value is the idle level
	assign syncIn = {~link.chipSelect_n, ~link.update_n, link.modeSerial};
	scsp_sync #(.WIDTH(3)) u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  (syncIn),
		.synced (syncOut)
	);
	logic [4:0] parSync;
	scsp_sync #(.WIDTH(5)) u_psync (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  (link.parallelBits),
		.synced (parSync)
	);
	logic selPrev;
	logic strobePrev;
	// Held word settled long before the synced select drops, safe to sample
	wire  wordArrived  = selPrev & ~syncOut[2];
	wire  strobeFall   = ~strobePrev & syncOut[1];
	wire  applyNow     = syncOut[0] & ((wordArrived & syncOut[1]) | strobeFall);
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			selPrev      <= 1'b0;
			strobePrev   <= 1'b0;
			switchWord   <= `SCSP_ZERO_WORD;
			parallelWord <= 5'h00;
			serialMode   <= 1'b0;
		end
		else
		begin
			selPrev    <= syncOut[2];
			strobePrev <= syncOut[1];
			serialMode <= syncOut[0];
			if (applyNow)
				switchWord <= holdWord;
			if (!syncOut[0])
				parallelWord <= parSync;
		end
	end
endmodule : scsp_device
`default_nettype wire

// ### verilog/scsp_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "scsp_regs.svh"
// Host end: divides clk to make the serial clock, sends one word
module scsp_host (
	input  wire logic        clk,
	input  wire logic        rst_n,
	scsp_if.host             link,
	input  wire logic        start,
	input  wire logic [23:0] txWord,
	input  wire logic        useStrobe,
	input  wire logic        selSerial,
	input  wire logic [4:0]  parIn,
	output logic             busy,
	output logic      [23:0] rxWord
);
	scsp_pkg::scsp_hstate_t state;
	logic [3:0]  div;
	logic [4:0]  count;
	logic [23:0] sh;
	logic        sclk;
	logic        csn;
	logic        strobe_n;
	logic        sdoSync;
	scsp_sync #(.WIDTH(1)) u_sdo (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  (link.serialOut),
		.synced (sdoSync)
	);
	wire tick = (div == `SCSP_DIV_HALF - 4'h1);
	assign link.serialClk    = sclk;
	assign link.chipSelect_n = csn;
	assign link.serialIn     = sh[23];
	assign link.update_n     = strobe_n;
	assign link.modeSerial   = selSerial;
	assign link.parallelBits = parIn;
	// Half periods of the serial clock paced by divider
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state    <= scsp_pkg::SCSP_IDLE;
			div      <= 4'h0;
			count    <= `SCSP_ZERO_CNT;
			sh       <= `SCSP_ZERO_WORD;
			sclk     <= 1'b1;
			csn      <= 1'b1;
			strobe_n <= 1'b1;
			busy     <= 1'b0;
			rxWord   <= `SCSP_ZERO_WORD;
		end
		else
		begin
			div <= tick ? 4'h0 : div + 4'h1;
			case (state)
				// Strobe stays low a tick past select rise, so the device sees both
				scsp_pkg::SCSP_IDLE: if (tick)
				begin
					strobe_n <= 1'b1;
					if (start)
					begin
						sh       <= txWord;
						csn      <= 1'b0;
						busy     <= 1'b1;
						count    <= `SCSP_ZERO_CNT;
						strobe_n <= ~useStrobe;
						state    <= scsp_pkg::SCSP_HIGH;
					end
				end
				scsp_pkg::SCSP_HIGH: if (tick)
				begin
					sclk <= 1'b0; // Device samples here
					count <= count + 5'h01;
					state <= scsp_pkg::SCSP_LOW;
				end
				scsp_pkg::SCSP_LOW: if (tick)
				begin
					sclk <= 1'b1;
					rxWord <= {rxWord[22:0], sdoSync};
					sh <= {sh[22:0], 1'b0};
					// Stop after 24 falls, before a 25th
					state <= (count == 5'(`SCSP_WORD_BITS)) ? scsp_pkg::SCSP_END
						: scsp_pkg::SCSP_HIGH;
				end
				scsp_pkg::SCSP_END: if (tick)
				begin
					// Raise select a half period after last sample
					csn <= 1'b1;
					busy <= 1'b0;
					state <= scsp_pkg::SCSP_IDLE;
				end
				default: state <= scsp_pkg::SCSP_IDLE;
			endcase
		end
	end
endmodule : scsp_host
`default_nettype wire

// ### verilog/scsp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface scsp_if;
	logic serialClk;
	logic chipSelect_n;
	logic serialIn;
	logic serialOut;
	logic serialOutEn;
	logic update_n;
	logic modeSerial;
	logic [4:0] parallelBits;
	modport device (
		input  serialClk, chipSelect_n, serialIn, update_n, modeSerial, parallelBits,
		output serialOut, serialOutEn
	);
	modport host (
		output serialClk, chipSelect_n, serialIn, update_n, modeSerial, parallelBits,
		input  serialOut, serialOutEn
	);
endinterface : scsp_if
`default_nettype wire

// ### verilog/scsp_pkg.sv
package scsp_pkg;
	typedef enum logic [1:0] {SCSP_IDLE, SCSP_LOW, SCSP_HIGH, SCSP_END} scsp_hstate_t;
endpackage : scsp_pkg

// ### verilog/scsp_regs.svh
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH
`define SCSP_WORD_BITS      24
`define SCSP_CNT_BITS       5
`define SCSP_PAR_BITS       5
`define SCSP_UPDATE_MAX_NS  145
`define SCSP_CLK_PERIOD_NS  4
`define SCSP_UPDATE_CYCLES  (`SCSP_UPDATE_MAX_NS / `SCSP_CLK_PERIOD_NS)
`define SCSP_DIV_HALF       4'h4
`define SCSP_DIV_BITS       4
`define SCSP_ZERO_WORD      24'h000000
`define SCSP_ZERO_CNT       5'h00
`endif

// ### verilog/scsp_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "scsp_regs.svh"
// Two-flop level synchroniser, one per bit
module scsp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async,
	output logic      [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage1;
	genvar i;
	// First stage read only by second stage
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					stage1[i] <= 1'b0;
					synced[i] <= 1'b0;
				end
				else
				begin
					stage1[i] <= async[i];
					synced[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule : scsp_sync
`default_nettype wire
